// [design/scs_clock_select.sv]
`timescale 1ns/1ps
// Function
// - auto-detect looks for a sync clock after each enable assertion
// - a found sync clock locks switching edges to its rising edges
// - no clock found in auto-detect mode: strap low 200 kHz, open 400 kHz, high 1 MHz
// - sync strap is read only at start-up, held until the next reset
// - a resistor on the sync pin maps through a fixed table
// - host may request 200 kHz to 1.33 MHz
// - programmed rates are 8 MHz divided by N, N from 6 to 40
// - inexact requests take the nearest achievable rate
// - reported frequency is the quantised operating rate
// - mode strap: low input, open auto-detect, high 400 kHz output
// - lost sync clock falls back to internal near last rate
module scs_clock_select
  import scs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic [1:0]  mode_strap,
  input  wire logic [1:0]  sync_strap,
  input  wire logic [4:0]  sync_res_index,
  input  wire logic        sync_in,
  input  wire logic        host_freq_wr,
  input  wire logic [10:0] host_freq_khz,
  output logic             sync_out,
  output logic             sync_oe,
  output logic             switching_clock,
  output logic [10:0]      switching_frequency_khz,
  output scs_status_s      status
);

  typedef struct packed {
    logic        en_meta;
    logic        en_q;
    logic        en_d;
    logic        sync_meta;
    logic        sync_q;
    logic        sync_d;
    logic [1:0]  mode_meta;
    logic [1:0]  mode_q;
    logic [1:0]  sstrap_meta;
    logic [1:0]  sstrap_q;
    logic [4:0]  res_meta;
    logic [4:0]  res_q;
    logic [1:0]  boot_cnt;
    scs_fsm_e    fsm;
    scs_lvl_e    cfg_mode;
    logic [5:0]  strap_div;
    logic [5:0]  host_div;
    logic        host_set;
    logic [5:0]  run_div;
    logic        run;
    logic        align;
    logic [1:0]  edges;
    logic [5:0]  gap;
    logic [5:0]  last_gap;
    logic [9:0]  tmr;
    logic        sync_out;
    logic        sync_oe;
    logic        sw_clk;
    logic [10:0] freq_khz;
    scs_status_s status;
  } scs_state_s;

  scs_state_s s;
  scs_state_s next_s;
  logic       ref_tick;
  logic       sw_level;
  logic       en_rise;
  logic       sync_rise;

  assign en_rise   = s.en_q && !s.en_d;
  assign sync_rise = s.sync_q && !s.sync_d;

  scs_sw_gen u_gen (
    .clock    (clock),
    .resetn   (resetn),
    .run      (s.run),
    .divisor  (s.run_div),
    .align    (s.align),
    .ref_tick (ref_tick),
    .sw_level (sw_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s             = s;
    next_s.en_meta     = enable;
    next_s.en_q        = s.en_meta;
    next_s.en_d        = s.en_q;
    next_s.sync_meta   = sync_in;
    next_s.sync_q      = s.sync_meta;
    next_s.sync_d      = s.sync_q;
    next_s.mode_meta   = mode_strap;
    next_s.mode_q      = s.mode_meta;
    next_s.sstrap_meta = sync_strap;
    next_s.sstrap_q    = s.sstrap_meta;
    next_s.res_meta    = sync_res_index;
    next_s.res_q       = s.res_meta;
    next_s.align       = 1'b0;
    // gap is counted in reference ticks so it doubles as a divisor
    if (ref_tick && s.gap != GAP_SAT) begin
      next_s.gap = s.gap + 6'h01;
    end
    if (host_freq_wr) begin
      next_s.host_div = nearest_div(host_freq_khz);
      next_s.host_set = 1'b1;
    end
    unique case (s.fsm)
      ST_BOOT: begin
        next_s.boot_cnt = s.boot_cnt + 2'h1;
        // straps are taken once, after the synchronisers have filled
        if (s.boot_cnt == BOOT_WAIT) begin
          next_s.fsm      = ST_WAIT_EN;
          next_s.cfg_mode = scs_lvl_e'(s.mode_q);
          unique case (scs_lvl_e'(s.sstrap_q))
            LVL_LOW:  next_s.strap_div = DIV_STRAP_LOW;
            LVL_OPEN: next_s.strap_div = DIV_STRAP_OPEN;
            LVL_HIGH: next_s.strap_div = DIV_STRAP_HIGH;
            LVL_RES:  next_s.strap_div = (s.res_q < RES_ENTRIES) ?
                                         RES_DIV[s.res_q] : DIV_STRAP_OPEN;
          endcase
        end
      end
      ST_WAIT_EN: begin
        if (en_rise) begin
          if (s.cfg_mode == LVL_HIGH) begin
            // sync output mode never listens to the pin
            next_s.fsm        = ST_RUN_INT;
            next_s.run_div    = host_freq_wr ? nearest_div(host_freq_khz) :
                                s.host_set ? s.host_div : DIV_SYNC_OUT;
            next_s.status.src = (host_freq_wr || s.host_set) ? SRC_HOST : SRC_PRESET;
          end else begin
            next_s.fsm   = ST_DETECT;
            next_s.tmr   = 10'h000;
            next_s.edges = 2'h0;
            next_s.gap   = 6'h00;
          end
        end
      end
      ST_DETECT: begin
        next_s.tmr = s.tmr + 10'h001;
        if (sync_rise) begin
          if (s.edges != 2'h0) begin
            next_s.last_gap = s.gap;
          end
          if (s.edges != 2'h3) begin
            next_s.edges = s.edges + 2'h1;
          end
          next_s.gap = 6'h00;
        end
        if (s.tmr == DETECT_LAST) begin
          next_s.tmr = 10'h000;
          if (s.edges >= 2'h2) begin
            next_s.fsm        = ST_RUN_EXT;
            next_s.run_div    = clamp_div(s.last_gap);
            next_s.status.src = SRC_EXT;
          end else begin
            next_s.fsm = ST_RUN_INT;
            if (host_freq_wr || s.host_set) begin
              next_s.run_div    = host_freq_wr ? nearest_div(host_freq_khz) : s.host_div;
              next_s.status.src = SRC_HOST;
            end else begin
              // input mode has no strap table; it runs the 400 kHz preset
              next_s.run_div    = (s.cfg_mode == LVL_OPEN) ? s.strap_div :
                                  DIV_SYNC_OUT;
              next_s.status.src = SRC_PRESET;
            end
          end
        end
      end
      ST_RUN_EXT: begin
        next_s.tmr = s.tmr + 10'h001;
        if (sync_rise) begin
          next_s.tmr      = 10'h000;
          next_s.last_gap = s.gap;
          next_s.gap      = 6'h00;
          next_s.run_div  = clamp_div(s.gap);
          next_s.align    = 1'b1;
        end else if (s.tmr == LOSS_LAST) begin
          // holdover keeps the last measured period, not the preset
          next_s.fsm        = ST_RUN_INT;
          next_s.run_div    = clamp_div(s.last_gap);
          next_s.status.src = SRC_HOLD;
        end
      end
      ST_RUN_INT: begin
        if (host_freq_wr) begin
          next_s.run_div    = nearest_div(host_freq_khz);
          next_s.status.src = SRC_HOST;
        end
      end
      default: begin
        next_s.fsm = ST_WAIT_EN;
      end
    endcase
    if (!s.en_q && s.fsm != ST_BOOT) begin
      next_s.fsm        = ST_WAIT_EN;
      next_s.status.src = SRC_IDLE;
    end
    next_s.run            = (next_s.fsm == ST_RUN_INT) || (next_s.fsm == ST_RUN_EXT);
    next_s.sw_clk         = sw_level;
    next_s.sync_oe        = (s.cfg_mode == LVL_HIGH) && s.run;
    next_s.sync_out       = (s.cfg_mode == LVL_HIGH) && sw_level;
    next_s.freq_khz       = s.run ? div_to_khz(s.run_div) : 11'h000;
    next_s.status.divisor = s.run_div;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s          <= '0;
      s.fsm      <= ST_BOOT;
      s.cfg_mode <= LVL_OPEN;
      s.run_div  <= DIV_SYNC_OUT;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out                = s.sync_out;
  assign sync_oe                 = s.sync_oe;
  assign switching_clock         = s.sw_clk;
  assign switching_frequency_khz = s.freq_khz;
  assign status                  = s.status;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_detect_on_enable: assert property (
    (s.fsm == ST_WAIT_EN && en_rise && s.en_q && s.cfg_mode != LVL_HIGH) |=> s.fsm == ST_DETECT)
    else $error("enable did not start sync detection");
  chk_ext_align: assert property (
    (s.fsm == ST_RUN_EXT && sync_rise && s.en_q) |-> ##[3:5] s.sw_clk)
    else $error("switching clock not aligned to sync edge");
  chk_strap_choice: assert property (
    (s.fsm == ST_DETECT && s.tmr == DETECT_LAST && s.edges < 2'h2 && s.en_q &&
     s.cfg_mode == LVL_OPEN && !s.host_set && !host_freq_wr) |=> s.run_div == s.strap_div)
    else $error("strap frequency not applied");
  chk_strap_frozen: assert property (
    (s.fsm != ST_BOOT) |=> $stable(s.strap_div) && $stable(s.cfg_mode))
    else $error("strap value changed after start-up");
  chk_res_lookup: assert property (
    (s.fsm == ST_BOOT && s.boot_cnt == BOOT_WAIT && s.sstrap_q == LVL_RES &&
     s.res_q == 5'h07) |=> s.strap_div == DIV_STRAP_OPEN)
    else $error("resistor lookup wrong");
  chk_host_nearest: assert property (
    (host_freq_wr && host_freq_khz == 11'h32A) |=> s.host_div == 6'h0A)
    else $error("host request not rounded to nearest");
  chk_div_range: assert property (
    s.run |-> (s.run_div >= 6'(DIV_MIN) && s.run_div <= 6'(DIV_MAX)))
    else $error("divisor out of range");
  chk_host_applied: assert property (
    (s.fsm == ST_RUN_INT && s.en_q && host_freq_wr) |=> s.run_div == nearest_div($past(host_freq_khz)))
    else $error("host divisor not applied");
  chk_report_quant: assert property (
    (s.run && $stable(s.run_div) && $past(s.run)) |=> s.freq_khz == div_to_khz($past(s.run_div)))
    else $error("reported frequency not quantised rate");
  chk_sync_out_mode: assert property (
    (s.cfg_mode != LVL_HIGH) |=> !s.sync_oe)
    else $error("sync pin driven outside output mode");
  chk_holdover: assert property (
    (s.fsm == ST_RUN_EXT && s.tmr == LOSS_LAST && !sync_rise && s.en_q) |=>
      (s.fsm == ST_RUN_INT && s.run_div == clamp_div($past(s.last_gap))))
    else $error("no holdover after sync loss");

  cov_ext_lock:  cover property (s.fsm == ST_DETECT ##1 s.fsm == ST_RUN_EXT);
  cov_holdover:  cover property (s.fsm == ST_RUN_EXT ##1 s.status.src == SRC_HOLD);
  cov_host_set:  cover property (s.fsm == ST_RUN_INT && host_freq_wr);
  cov_sync_out:  cover property (s.sync_oe && s.sync_out);

endmodule : scs_clock_select

// [design/scs_pkg.sv]
package scs_pkg;

  // pad sensing of three-level straps, plus a fitted resistor
  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_OPEN = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_RES  = 2'h3
  } scs_lvl_e;

  typedef enum logic [2:0] {
    ST_BOOT    = 3'h0,
    ST_WAIT_EN = 3'h1,
    ST_DETECT  = 3'h2,
    ST_RUN_INT = 3'h3,
    ST_RUN_EXT = 3'h4
  } scs_fsm_e;

  typedef enum logic [2:0] {
    SRC_IDLE   = 3'h0,
    SRC_PRESET = 3'h1,
    SRC_HOST   = 3'h2,
    SRC_EXT    = 3'h3,
    SRC_HOLD   = 3'h4
  } scs_src_e;

  typedef struct packed {
    scs_src_e   src;
    logic [5:0] divisor;
  } scs_status_s;

  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned REF_KHZ        = 8000;
  // 50 MHz * 4 / 25 = 8 MHz reference enable
  localparam logic [4:0]  ACC_STEP       = 5'h04;
  localparam logic [4:0]  ACC_MOD        = 5'h19;
  localparam int unsigned DIV_MIN        = 6;
  localparam int unsigned DIV_MAX        = 40;
  localparam logic [5:0]  DIV_STRAP_LOW  = 6'h28;
  localparam logic [5:0]  DIV_STRAP_OPEN = 6'h14;
  localparam logic [5:0]  DIV_STRAP_HIGH = 6'h08;
  localparam logic [5:0]  DIV_SYNC_OUT   = 6'h14;
  localparam logic [5:0]  GAP_SAT        = 6'h3F;
  localparam logic [1:0]  BOOT_WAIT      = 2'h3;
  localparam logic [4:0]  RES_ENTRIES    = 5'h13;
  localparam logic [5:0]  RES_DIV [19] = '{
    6'h28, 6'h24, 6'h21, 6'h1E, 6'h1B, 6'h19, 6'h16, 6'h14, 6'h13, 6'h11,
    6'h0F, 6'h0E, 6'h0D, 6'h0B, 6'h0A, 6'h09, 6'h08, 6'h07, 6'h06};
  localparam int unsigned DETECT_TIME_NS = 12000;
  localparam int unsigned DETECT_CYC     = (DETECT_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned LOSS_TIME_NS   = 10000;
  localparam int unsigned LOSS_CYC       = (LOSS_TIME_NS * CLK_MHZ) / 1000;
  localparam logic [9:0]  DETECT_LAST    = 10'(DETECT_CYC - 1);
  localparam logic [9:0]  LOSS_LAST      = 10'(LOSS_CYC - 1);

  function automatic logic [5:0] clamp_div(input logic [5:0] n);
    if (n < 6'(DIV_MIN)) return 6'(DIV_MIN);
    if (n > 6'(DIV_MAX)) return 6'(DIV_MAX);
    return n;
  endfunction : clamp_div

  function automatic logic [10:0] div_to_khz(input logic [5:0] n);
    int unsigned d;
    d = 32'(clamp_div(n));
    return 11'(REF_KHZ / d);
  endfunction : div_to_khz

  // nearest achievable 8 MHz / N to a request, measured in frequency
  function automatic logic [5:0] nearest_div(input logic [10:0] khz);
    int unsigned f;
    int unsigned fk;
    int unsigned err;
    int unsigned best_err;
    logic [5:0]  best;
    f        = 32'(khz);
    best_err = 32'hFFFF_FFFF;
    best     = 6'(DIV_MIN);
    for (int unsigned k = DIV_MIN; k <= DIV_MAX; k++) begin
      fk  = REF_KHZ / k;
      err = (fk > f) ? fk - f : f - fk;
      if (err < best_err) begin
        best_err = err;
        best     = 6'(k);
      end
    end
    return best;
  endfunction : nearest_div

endpackage : scs_pkg

// [design/scs_sw_gen.sv]
`timescale 1ns/1ps
module scs_sw_gen
  import scs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [5:0] divisor,
  input  wire logic       align,
  output logic            ref_tick,
  output logic            sw_level
);

  typedef struct packed {
    logic [4:0] acc;
    logic [5:0] cnt;
    logic       tick;
    logic       level;
  } scs_gen_s;

  scs_gen_s s;
  scs_gen_s next_s;
  logic [5:0] div_c;

  always_comb begin
    next_s = s;
    div_c  = clamp_div(divisor);
    if (s.acc + ACC_STEP >= ACC_MOD) begin
      next_s.acc  = s.acc + ACC_STEP - ACC_MOD;
      next_s.tick = 1'b1;
    end else begin
      next_s.acc  = s.acc + ACC_STEP;
      next_s.tick = 1'b0;
    end
    // restart of the count puts the switching edge on the sync edge
    if (!run || align) begin
      next_s.cnt = 6'h00;
    end else if (s.tick) begin
      next_s.cnt = (s.cnt >= div_c - 6'h01) ? 6'h00 : s.cnt + 6'h01;
    end
    next_s.level = run && (next_s.cnt < {1'b0, div_c[5:1]});
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ref_tick = s.tick;
  assign sw_level = s.level;

endmodule : scs_sw_gen

// [dv/scs_sync_peer.sv]
`timescale 1ns/1ps
// another controller strapped as the single sync source on the shared line
module scs_sync_peer #(
  parameter int unsigned LINK_HALF_NS = 80,
  parameter int unsigned HALVES       = 25
) (
  input  wire logic run,
  output logic      sync_line
);
  logic link_clk;
  int   cnt;

  ////////////////////////////////////////////////////////////////////////////
  // link clock stands still outside a run; the line is pulled low meanwhile
  initial begin
    link_clk  = 1'b0;
    sync_line = 1'b0;
    cnt       = 0;
    #7;
    forever begin
      if (run) begin
        #(LINK_HALF_NS);
        link_clk = ~link_clk;
        cnt      = cnt + 1;
        if (cnt >= HALVES) begin
          cnt       = 0;
          sync_line = ~sync_line;
        end
      end else begin
        sync_line = 1'b0;
        cnt       = 0;
        @(posedge run);
      end
    end
  end
endmodule : scs_sync_peer

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import scs_pkg::*;
();
  logic        clock;
  logic        resetn;
  logic        enable;
  logic [1:0]  mode_strap;
  logic [1:0]  sync_strap;
  logic [4:0]  sync_res_index;
  logic        host_freq_wr;
  logic [10:0] host_freq_khz;
  logic        peer_run;
  logic        peer_line;
  wire logic   sync_wire;
  logic        sync_out;
  logic        sync_oe;
  logic        switching_clock;
  logic [10:0] switching_frequency_khz;
  scs_status_s status;
  int          failures;
  int          tests_run;

  // the pin level: our driver wins while enabled, else the shared line
  assign sync_wire = sync_oe ? sync_out : peer_line;

  scs_clock_select dut (
    .clock                   (clock),
    .resetn                  (resetn),
    .enable                  (enable),
    .mode_strap              (mode_strap),
    .sync_strap              (sync_strap),
    .sync_res_index          (sync_res_index),
    .sync_in                 (sync_wire),
    .host_freq_wr            (host_freq_wr),
    .host_freq_khz           (host_freq_khz),
    .sync_out                (sync_out),
    .sync_oe                 (sync_oe),
    .switching_clock         (switching_clock),
    .switching_frequency_khz (switching_frequency_khz),
    .status                  (status)
  );

  scs_sync_peer peer (
    .run       (peer_run),
    .sync_line (peer_line)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi, input logic [5:0] got);
    tests_run++;
    if (^got === 1'bx || got < 6'(lo) || got > 6'(hi)) begin
      failures++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng

  // straps are set before reset lifts; enable toggles only after boot
  task automatic do_boot(input logic [1:0] m, input logic [1:0] s, input logic [4:0] r);
    enable         = 1'b0;
    resetn         = 1'b0;
    mode_strap     = m;
    sync_strap     = s;
    sync_res_index = r;
    step(2);
    resetn = 1'b1;
    step(8);
    enable = 1'b1;
    step(620);
  endtask : do_boot

  task automatic chk_run(input scs_src_e src, input logic [5:0] n);
    chk("src", 11'(src), 11'(status.src));
    chk("divisor", 11'(n), 11'(status.divisor));
    chk("freq", 11'(8000 / n), switching_frequency_khz);
  endtask : chk_run

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_straps();
    logic [1:0] s [6] = '{LVL_LOW, LVL_OPEN, LVL_HIGH, LVL_RES, LVL_RES, LVL_RES};
    logic [4:0] r [6] = '{5'h00, 5'h00, 5'h00, 5'h07, 5'h12, 5'h00};
    logic [5:0] n [6] = '{6'h28, 6'h14, 6'h08, 6'h14, 6'h06, 6'h28};
    for (int i = 0; i < 6; i++) begin
      do_boot(LVL_OPEN, s[i], r[i]);
      chk_run(SRC_PRESET, n[i]);
    end
  endtask : t_straps

  task automatic t_strap_held();
    do_boot(LVL_OPEN, LVL_HIGH, 5'h00);
    sync_strap = LVL_LOW;
    enable     = 1'b0;
    step(10);
    enable = 1'b1;
    step(620);
    chk_run(SRC_PRESET, 6'h08);
  endtask : t_strap_held

  task automatic t_host();
    logic [10:0] k [6] = '{11'h32A, 11'h064, 11'h7D0, 11'h535, 11'h0CD, 11'h10B};
    logic [5:0]  n [6] = '{6'h0A, 6'h28, 6'h06, 6'h06, 6'h27, 6'h1E};
    do_boot(LVL_OPEN, LVL_OPEN, 5'h00);
    for (int i = 0; i < 6; i++) begin
      host_freq_khz = k[i];
      host_freq_wr  = 1'b1;
      step(1);
      host_freq_wr = 1'b0;
      step(3);
      chk_run(SRC_HOST, n[i]);
    end
  endtask : t_host

  // 400 kHz off the 8 MHz reference is exactly 125 clock cycles between pin rises;
  // a pin that never toggles runs into the 400 cycle cap and mismatches
  task automatic chk_out_period();
    int   n;
    logic prev;
    n    = 0;
    prev = 1'b1;
    for (int k = 0; k < 2; k++) begin
      n    = 0;
      prev = 1'b1;
      while (!(sync_out && !prev) && n < 400) begin
        prev = sync_out;
        step(1);
        n++;
      end
    end
    chk("sync_out_period", 11'h07D, 11'(n));
  endtask : chk_out_period

  task automatic t_modes();
    do_boot(LVL_HIGH, LVL_HIGH, 5'h00);
    chk("sync_oe", 11'h001, 11'(sync_oe));
    chk("freq_out", 11'h190, switching_frequency_khz);
    chk_out_period();
    do_boot(LVL_LOW, LVL_HIGH, 5'h00);
    chk("sync_oe_in", 11'h000, 11'(sync_oe));
    chk("freq_in", 11'h190, switching_frequency_khz);
    chk("sync_out_in", 11'h000, 11'(sync_out));
  endtask : t_modes

  // 4 us sync period is 32 reference ticks; allow one tick of sampling jitter
  task automatic t_ext_and_loss();
    peer_run = 1'b1;
    step(400);
    do_boot(LVL_OPEN, LVL_OPEN, 5'h00);
    chk("src_ext", 11'(SRC_EXT), 11'(status.src));
    chk_rng("div_ext", 31, 33, status.divisor);
    @(posedge sync_wire);
    step(8);
    chk("aligned", 11'h001, 11'(switching_clock));
    peer_run = 1'b0;
    step(720);
    chk("src_hold", 11'(SRC_HOLD), 11'(status.src));
    chk_rng("div_hold", 31, 33, status.divisor);
    peer_run = 1'b1;
    enable   = 1'b0;
    step(400);
    enable = 1'b1;
    step(620);
    chk("src_redetect", 11'(SRC_EXT), 11'(status.src));
  endtask : t_ext_and_loss

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    failures       = 0;
    tests_run      = 0;
    resetn         = 1'b0;
    enable         = 1'b0;
    mode_strap     = LVL_OPEN;
    sync_strap     = LVL_OPEN;
    sync_res_index = 5'h00;
    host_freq_wr   = 1'b0;
    host_freq_khz  = 11'h000;
    peer_run       = 1'b0;
    t_straps();
    t_strap_held();
    t_host();
    t_modes();
    t_ext_and_loss();
    give_verdict();
  end

  // whole run is about 10000 cycles; this bound is about three times that
  initial begin
    #600000;
    failures++;
    give_verdict();
  end
endmodule : tb_top
